// File: rtl/lcr_pkg.sv
// Constants for the LED channel current register bank
package lcr_pkg;
  // Register addresses on the host port
  localparam logic [7:0] ADDR_CH2_FULL_SCALE = 8'h12;
  localparam logic [7:0] ADDR_CH2_FULL_SCALE_LOWPOWER = 8'h13;
  localparam logic [7:0] ADDR_CH1_CODE_HIGH = 8'h14;
  localparam logic [7:0] ADDR_CH1_CODE_LOW = 8'h15;
  localparam logic [7:0] ADDR_CH1_FULL_SCALE = 8'h16;
  localparam logic [7:0] ADDR_CH1_FULL_SCALE_LOWPOWER = 8'h17;
  localparam logic [7:0] ADDR_CH0_CODE_HIGH = 8'h18;
  localparam logic [7:0] ADDR_CH0_CODE_LOW = 8'h19;
  localparam int unsigned NUM_REGS = 8;
  localparam logic [7:0] ADDR_BASE = 8'h12;
  // Field layout
  localparam int unsigned SCALE_W = 6;
  localparam int unsigned CODE_HI_W = 2;
  localparam int unsigned CODE_W = 10;
  // Reset values
  localparam logic [5:0] SCALE_MAX = 6'h3f;
  localparam logic [5:0] RST_CH2_SCALE = 6'h3f;
  localparam logic [5:0] RST_CH2_SCALE_LP = 6'h3f;
  localparam logic [5:0] RST_CH1_SCALE = 6'h3f;
  localparam logic [5:0] RST_CH1_SCALE_LP = 6'h3f;
  localparam logic [1:0] RST_CODE_HIGH = 2'h0;
  localparam logic [7:0] RST_CODE_LOW = 8'h00;
endpackage

// File: rtl/lcr_regs.sv
// Channel full-scale and current-code register bank
//
// Contract
// RULE_01: Channel 2 normal full-scale code maps linearly; 63 is 2 A, 1 is 228.27 mA.
// RULE_02: Channel 2 normal full-scale field is bits 5..0; bits 7..6 reserved.
// RULE_03: Low-power pin low makes channel 2 use its low-power full-scale register.
// RULE_04: Channel 2 low-power code 1 is 228.27 mA, code 0 is 200 mA.
// RULE_05: Pin low uses channel 1 low-power register; it resets to 63 (2 A).
// RULE_06: Each 10-bit DAC code is high register bits 1..0 above low register.
`timescale 1ns/10ps
`default_nettype none
module lcr_regs (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_nrst,
  // Host register port, byte wide
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  // Mode pin, active low
  input wire logic i_low_power_select_pin_n,
  // DAC controls
  output logic [5:0] o_ch2_full_scale,
  output logic [5:0] o_ch1_full_scale,
  output logic [9:0] o_ch1_current_code,
  output logic [9:0] o_ch0_current_code
);
  // Reset is synchronous and active low: every scale register returns to the top
  // code and every current code half to zero, so the DACs start at zero current
  // whatever full scale they come up with.

  // Address map, every register byte wide and read/write
  //   0x12: channel 2 full scale, 0x13: channel 2 low-power full scale
  //   0x14, 0x15: channel 1 current code high and low halves
  //   0x16: channel 1 full scale, 0x17: channel 1 low-power full scale
  //   0x18, 0x19: channel 0 current code high and low halves
  // Other addresses are ignored on write and read as zero, so a host walking
  // the wider map never disturbs this bank.
  //
  // Timing at the ports
  //   A write taken on one edge is in its register after that edge; the
  //   selector or join stage copies it on the next edge, so the DAC outputs
  //   change two edges after the write is taken.
  //   A read taken on one edge puts out data and a one-cycle o_rvalid after it;
  //   the data then holds until the next read.
  // The mode pin is taken as synchronous; an off-chip pin needs a synchroniser
  // in front of this bank, which adds its own latency to the one-cycle pin lag.
  // Both channels see the same pin sample, so they never disagree on the mode.

  // Channel counts for the per-channel generate loops
  localparam int unsigned NUM_SCALE_CH = 2;
  localparam int unsigned NUM_CODE_CH = 2;

  // Storage; only defined bits are kept, reserved bits read zero
  logic [5:0] ch2_scale_field_ff;
  logic [5:0] ch2_scale_lp_ff;
  logic [1:0] ch1_code_high_ff;
  logic [7:0] ch1_code_low_ff;
  logic [5:0] ch1_scale_field_ff;
  logic [5:0] ch1_scale_lp_ff;
  logic [1:0] ch0_code_high_ff;
  logic [7:0] ch0_code_low_ff;
  logic [7:0] rdata_ff;
  logic rvalid_ff;
  logic [7:0] nxt_rdata;
  // Per-channel views feeding the generate loops below
  logic [5:0] scale_normal [NUM_SCALE_CH];
  logic [5:0] scale_lowpower [NUM_SCALE_CH];
  logic [5:0] scale_out [NUM_SCALE_CH];
  logic [1:0] code_high [NUM_CODE_CH];
  logic [7:0] code_low [NUM_CODE_CH];
  logic [9:0] code_out [NUM_CODE_CH];

  // Channel 2 full-scale registers
  // Both are kept whatever the pin says, so software can preload the low-power value
  // RULE_02: six-bit field only
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      ch2_scale_field_ff <= lcr_pkg::RST_CH2_SCALE;
      ch2_scale_lp_ff <= lcr_pkg::RST_CH2_SCALE_LP;
    end else if (i_wr_en) begin
      if (i_addr == lcr_pkg::ADDR_CH2_FULL_SCALE) begin
        ch2_scale_field_ff <= i_wdata[5:0];
      end
      // RULE_04: code 0 allowed, 200 mA
      if (i_addr == lcr_pkg::ADDR_CH2_FULL_SCALE_LOWPOWER) begin
        ch2_scale_lp_ff <= i_wdata[5:0];
      end
    end
  end

  // Channel 1 full-scale registers
  // Same split as channel 2; the pin only chooses which one reaches the DAC
  // RULE_05: low-power resets to maximum
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      ch1_scale_field_ff <= lcr_pkg::RST_CH1_SCALE;
      ch1_scale_lp_ff <= lcr_pkg::RST_CH1_SCALE_LP;
    end else if (i_wr_en) begin
      if (i_addr == lcr_pkg::ADDR_CH1_FULL_SCALE) begin
        ch1_scale_field_ff <= i_wdata[5:0];
      end
      if (i_addr == lcr_pkg::ADDR_CH1_FULL_SCALE_LOWPOWER) begin
        ch1_scale_lp_ff <= i_wdata[5:0];
      end
    end
  end

  // Current code halves for channels 1 and 0
  // High halves keep only bits 1..0; the upper six bits of a write are dropped
  // Each half is written on its own; there is no staging of the pair
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      ch1_code_high_ff <= lcr_pkg::RST_CODE_HIGH;
      ch1_code_low_ff <= lcr_pkg::RST_CODE_LOW;
      ch0_code_high_ff <= lcr_pkg::RST_CODE_HIGH;
      ch0_code_low_ff <= lcr_pkg::RST_CODE_LOW;
    end else if (i_wr_en) begin
      case (i_addr)
        lcr_pkg::ADDR_CH1_CODE_HIGH: begin
          ch1_code_high_ff <= i_wdata[1:0];
        end
        lcr_pkg::ADDR_CH1_CODE_LOW: begin
          ch1_code_low_ff <= i_wdata;
        end
        lcr_pkg::ADDR_CH0_CODE_HIGH: begin
          ch0_code_high_ff <= i_wdata[1:0];
        end
        lcr_pkg::ADDR_CH0_CODE_LOW: begin
          ch0_code_low_ff <= i_wdata;
        end
        default: begin
        end
      endcase
    end
  end

  // Per-channel code halves; index 0 is channel 1, index 1 is channel 0
  assign code_high[0] = ch1_code_high_ff;
  assign code_low[0] = ch1_code_low_ff;
  assign code_high[1] = ch0_code_high_ff;
  assign code_low[1] = ch0_code_low_ff;

  // RULE_06: join high and low parts
  // Halves update independently and there is no shadow copy, so a DAC sees a mixed
  // code between the two writes; a host needing a clean step changes one half only
  for (genvar ch = 0; ch < NUM_CODE_CH; ch++) begin : g_code
    logic [9:0] code_ff;
    // Registered join keeps every DAC code output straight from a flip-flop
    // and gives the code the same two-edge latency as the full scale
    always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
        code_ff <= {lcr_pkg::RST_CODE_HIGH, lcr_pkg::RST_CODE_LOW};
      end else begin
        code_ff <= {code_high[ch], code_low[ch]};
      end
    end
    assign code_out[ch] = code_ff;
  end

  // Read mux; unmapped addresses read zero
  // Reads have no side effects, so a host may poll any register freely
  always_comb begin
    nxt_rdata = 8'h00;
    case (i_addr)
      lcr_pkg::ADDR_CH2_FULL_SCALE: nxt_rdata = {2'h0, ch2_scale_field_ff};
      lcr_pkg::ADDR_CH2_FULL_SCALE_LOWPOWER: nxt_rdata = {2'h0, ch2_scale_lp_ff};
      lcr_pkg::ADDR_CH1_CODE_HIGH: nxt_rdata = {6'h00, ch1_code_high_ff};
      lcr_pkg::ADDR_CH1_CODE_LOW: nxt_rdata = ch1_code_low_ff;
      lcr_pkg::ADDR_CH1_FULL_SCALE: nxt_rdata = {2'h0, ch1_scale_field_ff};
      lcr_pkg::ADDR_CH1_FULL_SCALE_LOWPOWER: nxt_rdata = {2'h0, ch1_scale_lp_ff};
      lcr_pkg::ADDR_CH0_CODE_HIGH: nxt_rdata = {6'h00, ch0_code_high_ff};
      lcr_pkg::ADDR_CH0_CODE_LOW: nxt_rdata = ch0_code_low_ff;
      default: nxt_rdata = 8'h00;
    endcase
  end

  // Read data registered; held until next read
  // Holding the data lets a slow host sample it well after the valid pulse
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= i_rd_en;
      if (i_rd_en) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  // Per-channel full-scale sources; index 0 is channel 2, index 1 is channel 1
  assign scale_normal[0] = ch2_scale_field_ff;
  assign scale_lowpower[0] = ch2_scale_lp_ff;
  assign scale_normal[1] = ch1_scale_field_ff;
  assign scale_lowpower[1] = ch1_scale_lp_ff;

  // RULE_01: raw code, linear outside
  // RULE_05: channel 1 low-power selection
  // One pin steers both channels, so they switch full scale on the same clock edge
  for (genvar ch = 0; ch < NUM_SCALE_CH; ch++) begin : g_scale
    lcr_scale_select u_sel (
      .i_clock(i_clock),
      .i_nrst(i_nrst),
      .i_low_power_select_pin_n(i_low_power_select_pin_n),
      .i_scale_normal(scale_normal[ch]),
      .i_scale_lowpower(scale_lowpower[ch]),
      .o_scale(scale_out[ch])
    );
  end

  // Outputs; each traces back to a flip-flop in a selector, join or read stage
  assign o_rdata = rdata_ff;
  assign o_rvalid = rvalid_ff;
  assign o_ch2_full_scale = scale_out[0];
  assign o_ch1_full_scale = scale_out[1];
  assign o_ch1_current_code = code_out[0];
  assign o_ch0_current_code = code_out[1];
endmodule
`default_nettype wire

// File: rtl/lcr_scale_select.sv
// Full-scale selector between normal and low-power register
`timescale 1ns/10ps
`default_nettype none
module lcr_scale_select (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_nrst,
  // Selection
  input wire logic i_low_power_select_pin_n,
  input wire logic [5:0] i_scale_normal,
  input wire logic [5:0] i_scale_lowpower,
  // Result
  output logic [5:0] o_scale
);
  logic [5:0] scale_ff;
  // RULE_03: low pin selects low-power
  // Registered so the DAC sees a clean code, one cycle after pin or register change
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      scale_ff <= lcr_pkg::SCALE_MAX;
    end else if (!i_low_power_select_pin_n) begin
      scale_ff <= i_scale_lowpower;
    end else begin
      scale_ff <= i_scale_normal;
    end
  end
  assign o_scale = scale_ff;
endmodule
`default_nettype wire

// File: verification/lcr_regs_asserts.sv
// Port checker for the channel current register bank
`timescale 1ns/10ps
`default_nettype none
module lcr_regs_chk (
  // Clock, reset and host port
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  input wire logic o_rvalid,
  // Mode pin and DAC controls
  input wire logic i_low_power_select_pin_n,
  input wire logic [5:0] o_ch2_full_scale,
  input wire logic [5:0] o_ch1_full_scale,
  input wire logic [9:0] o_ch1_current_code,
  input wire logic [9:0] o_ch0_current_code
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  // Scale writes reach the DAC two edges later, judged with the pin level of the middle edge
  a_ch2_norm_scale: assert property ((i_wr_en && i_addr == 8'h12) ##1 i_low_power_select_pin_n
    |=> o_ch2_full_scale == $past(i_wdata[5:0], 2)) else $error("ch2 normal scale wrong");
  a_ch2_lp_scale: assert property ((i_wr_en && i_addr == 8'h13) ##1 !i_low_power_select_pin_n
    |=> o_ch2_full_scale == $past(i_wdata[5:0], 2)) else $error("ch2 low-power scale wrong");
  a_ch1_lp_scale: assert property ((i_wr_en && i_addr == 8'h17) ##1 !i_low_power_select_pin_n
    |=> o_ch1_full_scale == $past(i_wdata[5:0], 2)) else $error("ch1 low-power scale wrong");
  a_ch1_code_low: assert property (i_wr_en && i_addr == 8'h15
    |-> ##2 o_ch1_current_code[7:0] == $past(i_wdata, 2)) else $error("ch1 code low bits wrong");
  a_ch0_code_high: assert property (i_wr_en && i_addr == 8'h18
    |-> ##2 o_ch0_current_code[9:8] == $past(i_wdata[1:0], 2)) else $error("ch0 code high bits wrong");
  a_scale_rsvd_zero: assert property (i_rd_en && i_addr inside {8'h12, 8'h13}
    |=> o_rvalid && o_rdata[7:6] == 2'h0) else $error("scale reserved bits not zero");
  // Reset must load the top code even while held, so this one is not disabled
  a_reset_lp_max: assert property (disable iff (1'h0) !i_nrst
    |=> o_ch1_full_scale == 6'h3f) else $error("ch1 scale not maximum after reset");
  c_lp_write: cover property ((i_wr_en && i_addr == 8'h13) ##1 !i_low_power_select_pin_n);
  c_code_write: cover property (i_wr_en && i_addr == 8'h18);
  c_scale_read: cover property (i_rd_en && i_addr == 8'h12);
endmodule
`default_nettype wire

// File: verification/tb.sv
// Self-checking bench for the channel current register bank
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic i_clock = 0, i_nrst = 0, i_wr_en = 0, i_rd_en = 0, pin_n = 1, o_rvalid;
  logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata;
  logic [5:0] s2, s1;
  logic [9:0] c1, c0;
  int n_errors = 0, checks = 0;
  // 40 MHz clock
  always #12.5 i_clock = ~i_clock;
  lcr_regs dut (.i_clock(i_clock), .i_nrst(i_nrst), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
    .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
    .i_low_power_select_pin_n(pin_n), .o_ch2_full_scale(s2), .o_ch1_full_scale(s1),
    .o_ch1_current_code(c1), .o_ch0_current_code(c0));
  task automatic chk(input string what, input logic [9:0] seen, input logic [9:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Write strobe for one edge, then wait until the DAC outputs settle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clock);
    i_wr_en = 1;
    i_addr = a;
    i_wdata = d;
    @(negedge i_clock);
    i_wr_en = 0;
    @(negedge i_clock);
  endtask
  // Read strobe; valid and data judged a cycle later, then valid gone and data held
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge i_clock);
    i_rd_en = 1;
    i_addr = a;
    @(negedge i_clock);
    i_rd_en = 0;
    chk("read", {1'h0, o_rvalid, o_rdata}, {2'h1, exp});
    @(negedge i_clock);
    chk("read hold", {1'h0, o_rvalid, o_rdata}, {2'h0, exp});
  endtask
  task automatic pin(input logic v);
    pin_n = v;
    @(negedge i_clock);
  endtask
  task t_reset;
    pin(0);
    chk("ch1 scale", s1, 10'h03f);
    rd(8'h17, 8'h3f);
    rd(8'h14, 8'h00);
    pin(1);
  endtask
  task t_ch2_normal;
    logic [7:0] v[3];
    v = '{8'hc1, 8'h1c, 8'hff};
    foreach (v[i]) begin
      wr(8'h12, v[i]);
      chk("ch2 scale", s2, {4'h0, v[i][5:0]});
      rd(8'h12, v[i] & 8'h3f);
    end
  endtask
  task t_lowpower;
    wr(8'h13, 8'h00);
    wr(8'h17, 8'h05);
    wr(8'h12, 8'h1c);
    wr(8'h16, 8'h2a);
    pin(0);
    chk("ch2 lp scale", s2, 10'h000);
    chk("ch1 lp scale", s1, 10'h005);
    wr(8'h13, 8'h41);
    chk("ch2 lp scale", s2, 10'h001);
    pin(1);
    chk("ch2 scale", s2, 10'h01c);
    chk("ch1 scale", s1, 10'h02a);
  endtask
  // Reset in mid-run brings back the reset values
  task t_midreset;
    wr(8'h12, 8'h05);
    wr(8'h15, 8'h33);
    i_nrst = 0;
    @(negedge i_clock);
    i_nrst = 1;
    @(negedge i_clock);
    chk("ch2 scale reset", s2, 10'h03f);
    chk("ch1 code reset", c1, 10'h000);
    rd(8'h17, 8'h3f);
  endtask
  task t_codes;
    wr(8'h14, 8'hff);
    wr(8'h15, 8'ha5);
    chk("ch1 code", c1, 10'h3a5);
    rd(8'h14, 8'h03);
    wr(8'h18, 8'hfe);
    wr(8'h19, 8'h5a);
    chk("ch0 code", c0, 10'h25a);
    wr(8'h1a, 8'h55);
    rd(8'h1a, 8'h00);
    rd(8'h17, 8'h05);
  endtask
  task give_verdict;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Main sequence after an eight-cycle reset
  initial begin
    repeat (8) @(negedge i_clock);
    i_nrst = 1;
    t_reset;
    t_ch2_normal;
    t_lowpower;
    t_codes;
    t_midreset;
    give_verdict;
  end
  // Watchdog well past the expected 86 cycles
  initial begin
    #75000;
    n_errors++;
    give_verdict;
  end
endmodule
bind lcr_regs lcr_regs_chk u_chk (.i_clock(i_clock), .i_nrst(i_nrst), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
  .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
  .i_low_power_select_pin_n(i_low_power_select_pin_n), .o_ch2_full_scale(o_ch2_full_scale),
  .o_ch1_full_scale(o_ch1_full_scale), .o_ch1_current_code(o_ch1_current_code),
  .o_ch0_current_code(o_ch0_current_code));
`default_nettype wire
